/* include/lcd_consts.svh */
// Constants for the LIN command frame decoder.
// Assumes a byte-level LIN data-link layer in front of the decoder.
//
// Behaviour
// - Application frames use assigned identifiers; only 0x3C and 0x7D are fixed.
// - Frame length and layout are chosen by the protected identifier alone.
// - Shared identifiers pick the command from a command byte in the payload.
// - Addressed writing frames execute only for own node address or broadcast.
// - Broadcast node address 0x7F makes every subscribed slave execute.
// - First shared frame: address, command, five data bytes, then checksum.
// - First shared frame codes: 0x08, 0x09, 0x10, 0x16, 0x2F.
// - Stop-type codes 0x04,0x05,0x06,0x0F; second frame has address, third none.
// - Short status: switch, step loss, defect, undervoltage, shutdown, warning, temp[1:0].
// - Hard stop halts at once; soft stop halts through deceleration.
// - Reset position makes current position the new zero.
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH

`define LCD_PID_DIAG_REQ 8'h3C
`define LCD_PID_DIAG_RESP 8'h7D
`define LCD_NAD_BROADCAST 8'h7F
`define LCD_UNUSED_BYTE 8'hFF

`define LCD_CMD_SAFE_POS 8'h04
`define LCD_CMD_HALT 8'h05
`define LCD_CMD_ZERO 8'h06
`define LCD_CMD_DUAL_MOVE 8'h08
`define LCD_CMD_MOTION_PARAM 8'h09
`define LCD_CMD_OTP_BYTE 8'h10
`define LCD_CMD_DECEL_HALT 8'h0F
`define LCD_CMD_STALL_PARAM 8'h16
`define LCD_CMD_MOVE_PARAMS 8'h2F

`define LCD_LEN_WIDE 4'h7
`define LCD_LEN_ADDR 4'h2
`define LCD_LEN_BARE 4'h1
`define LCD_LEN_STATUS 4'h1

`endif

/* include/lcd_pkg.sv */
// Types for the LIN command frame decoder.
// Assumes lcd_consts.svh is compiled alongside.
package lcd_pkg;
    typedef enum logic [2:0] {
        LCD_K_NONE,
        LCD_K_WIDE,
        LCD_K_ADDR,
        LCD_K_BARE,
        LCD_K_STATUS
    } lcd_kind_t;
    typedef enum logic [1:0] {
        LCD_S_IDLE,
        LCD_S_RECV,
        LCD_S_CHECK,
        LCD_S_SEND
    } lcd_state_t;
endpackage

/* src/lcd_payload_mem.sv */
// Payload byte store for one received frame.
// Assumes single clock; read data registered.
`timescale 1ns/1ps
module lcd_payload_mem #(
    parameter int DEPTH = 8
) (
    // Clock
    input wire logic clock,
    // Write side
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read side
    input wire logic [2:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        rd_data <= mem[rd_addr];
    end
endmodule // lcd_payload_mem

/* src/lcd_frame_decoder.sv */
// LIN application frame decoder for a stepper positioner slave.
// Assumes a data-link layer that delivers header and payload bytes and checks checksums.
`timescale 1ns/1ps
`include "lcd_consts.svh"
module lcd_frame_decoder import lcd_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Identity and assigned identifiers
    input wire logic [7:0] node_address,
    input wire logic [7:0] pid_wide,
    input wire logic [7:0] pid_addr,
    input wire logic [7:0] pid_bare,
    input wire logic [7:0] pid_status,
    // Header and payload from data-link layer
    input wire logic header_valid,
    input wire logic [7:0] header_pid,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic frame_end,
    input wire logic checksum_ok,
    // Status inputs
    input wire logic external_switch_flag,
    input wire logic missed_step_flag,
    input wire logic electrical_defect_flag,
    input wire logic undervoltage_flag,
    input wire logic thermal_shutdown_flag,
    input wire logic thermal_warning_flag,
    input wire logic [1:0] temp_info,
    // Response to data-link layer
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic [3:0] frame_length,
    // Command strobes
    output logic dual_move_cmd,
    output logic motion_param_cmd,
    output logic otp_byte_program_cmd,
    output logic stall_detect_param_cmd,
    output logic move_with_params_cmd,
    output logic safe_position_cmd,
    output logic immediate_halt_cmd,
    output logic zero_here_cmd,
    output logic decel_halt_cmd,
    // Parameter bytes of last accepted wide frame; rejected-frame strobe
    output logic [39:0] cmd_data,
    output logic frame_rejected
);
    // ------------------------------------------------------------
    // Frame kind from identifier
    // ------------------------------------------------------------
    lcd_state_t state_reg;
    lcd_kind_t kind_reg;
    lcd_kind_t kind_next;
    logic [2:0] count_reg;
    logic [2:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] nad_reg;
    logic [7:0] cmd_reg;
    logic [39:0] data_reg;
    logic addr_ok;
    logic cmd_ok;
    logic accept;

    // Layout chosen only from the identifier; fixed diag ids never match
    always_comb begin
        kind_next = LCD_K_NONE;
        if (header_pid == `LCD_PID_DIAG_REQ || header_pid == `LCD_PID_DIAG_RESP) begin
            kind_next = LCD_K_NONE;
        end else if (header_pid == pid_wide) begin
            kind_next = LCD_K_WIDE;
        end else if (header_pid == pid_addr) begin
            kind_next = LCD_K_ADDR;
        end else if (header_pid == pid_bare) begin
            kind_next = LCD_K_BARE;
        end else if (header_pid == pid_status) begin
            kind_next = LCD_K_STATUS;
        end
    end

    always_comb begin
        case (kind_reg)
            LCD_K_WIDE: frame_length = `LCD_LEN_WIDE;
            LCD_K_ADDR: frame_length = `LCD_LEN_ADDR;
            LCD_K_BARE: frame_length = `LCD_LEN_BARE;
            LCD_K_STATUS: frame_length = `LCD_LEN_STATUS;
            default: frame_length = 4'h0;
        endcase
    end

    // ------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------
    // Slave only reacts after a master header
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg <= LCD_S_IDLE;
            kind_reg <= LCD_K_NONE;
            count_reg <= 3'h0;
        end else if (header_valid) begin
            kind_reg <= kind_next;
            count_reg <= 3'h0;
            case (kind_next)
                LCD_K_NONE: state_reg <= LCD_S_IDLE;
                LCD_K_STATUS: state_reg <= LCD_S_SEND;
                default: state_reg <= LCD_S_RECV;
            endcase
        end else begin
            case (state_reg)
                LCD_S_RECV: begin
                    if (rx_valid && count_reg != 3'h7) begin
                        count_reg <= count_reg + 3'h1;
                    end
                    if (frame_end) begin
                        state_reg <= LCD_S_CHECK;
                    end
                end
                LCD_S_CHECK: state_reg <= LCD_S_IDLE;
                LCD_S_SEND: state_reg <= LCD_S_IDLE;
                default: state_reg <= LCD_S_IDLE;
            endcase
        end
    end

    lcd_payload_mem #(.DEPTH(8)) u_mem (
        .clock(clock),
        .wr_en(state_reg == LCD_S_RECV && rx_valid),
        .wr_addr(count_reg),
        .wr_data(rx_byte),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // Capture fields by position within the layout
    always_ff @(posedge clock) begin
        if (!rstn) begin
            nad_reg <= 8'h00;
            cmd_reg <= 8'h00;
        end else if (state_reg == LCD_S_RECV && rx_valid) begin
            if (kind_reg == LCD_K_BARE) begin
                if (count_reg == 3'h0) begin
                    cmd_reg <= rx_byte;
                end
            end else if (count_reg == 3'h0) begin
                nad_reg <= rx_byte;
            end else if (count_reg == 3'h1) begin
                cmd_reg <= rx_byte;
            end
        end
    end

    // Memory read address follows count_reg during receive, zero otherwise
    always_comb begin
        rd_addr = 3'h0;
        if (state_reg == LCD_S_RECV) begin
            rd_addr = count_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            data_reg <= {5{`LCD_UNUSED_BYTE}};
        end else if (state_reg == LCD_S_RECV && rx_valid && kind_reg == LCD_K_WIDE
                     && count_reg >= 3'h2 && count_reg <= 3'h6) begin
            data_reg <= {data_reg[31:0], rx_byte};
        end
    end

    // ------------------------------------------------------------
    // Acceptance and command dispatch
    // ------------------------------------------------------------
    assign addr_ok = (kind_reg == LCD_K_BARE) || (nad_reg == node_address)
                     || (nad_reg == `LCD_NAD_BROADCAST);

    always_comb begin
        cmd_ok = 1'b0;
        if (kind_reg == LCD_K_WIDE) begin
            cmd_ok = cmd_reg == `LCD_CMD_DUAL_MOVE || cmd_reg == `LCD_CMD_MOTION_PARAM
                || cmd_reg == `LCD_CMD_OTP_BYTE || cmd_reg == `LCD_CMD_STALL_PARAM
                || cmd_reg == `LCD_CMD_MOVE_PARAMS;
        end else if (kind_reg == LCD_K_ADDR || kind_reg == LCD_K_BARE) begin
            cmd_ok = cmd_reg == `LCD_CMD_SAFE_POS || cmd_reg == `LCD_CMD_HALT
                || cmd_reg == `LCD_CMD_ZERO || cmd_reg == `LCD_CMD_DECEL_HALT;
        end
    end

    assign accept = state_reg == LCD_S_CHECK && checksum_ok && addr_ok && cmd_ok;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            dual_move_cmd <= 1'b0;
            motion_param_cmd <= 1'b0;
            otp_byte_program_cmd <= 1'b0;
            stall_detect_param_cmd <= 1'b0;
            move_with_params_cmd <= 1'b0;
            safe_position_cmd <= 1'b0;
            immediate_halt_cmd <= 1'b0;
            zero_here_cmd <= 1'b0;
            decel_halt_cmd <= 1'b0;
            frame_rejected <= 1'b0;
        end else begin
            dual_move_cmd <= accept && cmd_reg == `LCD_CMD_DUAL_MOVE;
            motion_param_cmd <= accept && cmd_reg == `LCD_CMD_MOTION_PARAM;
            otp_byte_program_cmd <= accept && cmd_reg == `LCD_CMD_OTP_BYTE;
            stall_detect_param_cmd <= accept && cmd_reg == `LCD_CMD_STALL_PARAM;
            move_with_params_cmd <= accept && cmd_reg == `LCD_CMD_MOVE_PARAMS;
            safe_position_cmd <= accept && cmd_reg == `LCD_CMD_SAFE_POS;
            immediate_halt_cmd <= accept && cmd_reg == `LCD_CMD_HALT;
            zero_here_cmd <= accept && cmd_reg == `LCD_CMD_ZERO;
            decel_halt_cmd <= accept && cmd_reg == `LCD_CMD_DECEL_HALT;
            frame_rejected <= state_reg == LCD_S_CHECK && !accept;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cmd_data <= {5{`LCD_UNUSED_BYTE}};
        end else if (accept && kind_reg == LCD_K_WIDE) begin
            cmd_data <= data_reg;
        end
    end

    // ------------------------------------------------------------
    // Short status response
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            tx_valid <= 1'b0;
            tx_byte <= 8'h00;
        end else begin
            tx_valid <= state_reg == LCD_S_SEND && !header_valid;
            if (state_reg == LCD_S_SEND) begin
                tx_byte <= {external_switch_flag, missed_step_flag, electrical_defect_flag,
                            undervoltage_flag, thermal_shutdown_flag, thermal_warning_flag,
                            temp_info};
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_no_reject_exec;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LCD_S_CHECK && !checksum_ok) |=> !dual_move_cmd && !immediate_halt_cmd
            && !zero_here_cmd && !decel_halt_cmd && !safe_position_cmd;
    endproperty
    a_no_reject_exec: assert property (p_no_reject_exec) else $error("exec on bad frame");

    property p_foreign_nad;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LCD_S_CHECK && kind_reg != LCD_K_BARE && nad_reg != node_address
            && nad_reg != `LCD_NAD_BROADCAST) |=> frame_rejected;
    endproperty
    a_foreign_nad: assert property (p_foreign_nad) else $error("foreign address taken");

    property p_broadcast;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LCD_S_CHECK && checksum_ok && cmd_ok && kind_reg != LCD_K_BARE
            && nad_reg == `LCD_NAD_BROADCAST) |=> !frame_rejected;
    endproperty
    a_broadcast: assert property (p_broadcast) else $error("broadcast dropped");

    property p_tx_only_status;
        @(posedge clock) disable iff (!rstn)
        tx_valid |-> $past(kind_reg) == LCD_K_STATUS;
    endproperty
    a_tx_only_status: assert property (p_tx_only_status) else $error("unasked response");

    property p_status_order;
        @(posedge clock) disable iff (!rstn)
        tx_valid |-> tx_byte[7] == $past(external_switch_flag)
            && tx_byte[1:0] == $past(temp_info);
    endproperty
    a_status_order: assert property (p_status_order) else $error("status bit order");

    property p_halt_code;
        @(posedge clock) disable iff (!rstn)
        immediate_halt_cmd |-> $past(cmd_reg) == `LCD_CMD_HALT && $past(accept);
    endproperty
    a_halt_code: assert property (p_halt_code) else $error("halt decode");

    property p_zero_code;
        @(posedge clock) disable iff (!rstn)
        zero_here_cmd |-> $past(cmd_reg) == `LCD_CMD_ZERO && $past(kind_reg) != LCD_K_WIDE;
    endproperty
    a_zero_code: assert property (p_zero_code) else $error("zero decode");

    property p_wide_len;
        @(posedge clock) disable iff (!rstn)
        (header_valid && header_pid == pid_wide && header_pid != `LCD_PID_DIAG_REQ
            && header_pid != `LCD_PID_DIAG_RESP) |=> frame_length == `LCD_LEN_WIDE;
    endproperty
    a_wide_len: assert property (p_wide_len) else $error("wide length");

    property p_diag_ignored;
        @(posedge clock) disable iff (!rstn)
        (header_valid && header_pid == `LCD_PID_DIAG_REQ) |=> state_reg == LCD_S_IDLE;
    endproperty
    a_diag_ignored: assert property (p_diag_ignored) else $error("diag id decoded");

    property p_wide_codes;
        @(posedge clock) disable iff (!rstn)
        dual_move_cmd || move_with_params_cmd |-> $past(kind_reg) == LCD_K_WIDE;
    endproperty
    a_wide_codes: assert property (p_wide_codes) else $error("wide code on short frame");
endmodule // lcd_frame_decoder

/* test/lcd_master_model.sv */
// LIN master model: sends header, payload bytes and frame end.
// Assumes a bench that calls send_frame; lines change at falling edge.
`timescale 1ns/1ps
module lcd_master_model (
    // Clock
    input wire logic clock,
    // Frame lines
    output logic header_valid,
    output logic [7:0] header_pid,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic frame_end,
    output logic checksum_ok
);
    initial begin
        header_valid = 1'b0;
        header_pid = 8'h00;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        frame_end = 1'b0;
        checksum_ok = 1'b0;
    end

    // Released lines show the inverse of their last value
    task automatic send_frame(input logic [7:0] pid, input logic [63:0] b,
                              input int n, input logic ok);
        @(negedge clock);
        header_valid = 1'b1;
        header_pid = pid;
        @(negedge clock);
        header_valid = 1'b0;
        header_pid = ~pid;
        for (int i = 0; i < n; i++) begin
            rx_valid = 1'b1;
            rx_byte = b[63 - 8 * i -: 8];
            @(negedge clock);
        end
        if (n > 0) begin
            rx_valid = 1'b0;
            rx_byte = ~rx_byte;
            frame_end = 1'b1;
            checksum_ok = ok;
            @(negedge clock);
            frame_end = 1'b0;
            @(negedge clock);
            checksum_ok = ~ok;
        end
        repeat (4) @(negedge clock);
    endtask
endmodule // lcd_master_model

/* test/lcd_frame_decoder_tb_top.sv */
// Bench for the frame decoder: queued expectations, output monitor.
// Assumes lcd_pkg and lcd_consts.svh; master model drives the frames.
`timescale 1ns/1ps
`include "lcd_consts.svh"
module lcd_frame_decoder_tb_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] node_address = 8'h00;
    logic [7:0] pid_wide = 8'h11;
    logic [7:0] pid_addr = 8'h22;
    logic [7:0] pid_bare = 8'h33;
    logic [7:0] pid_status = 8'h44;
    logic header_valid, rx_valid, frame_end, checksum_ok;
    logic [7:0] header_pid, rx_byte, tx_byte;
    logic [7:0] stat = 8'h00;
    logic external_switch_flag, missed_step_flag, electrical_defect_flag;
    logic undervoltage_flag, thermal_shutdown_flag, thermal_warning_flag;
    logic [1:0] temp_info;
    logic tx_valid, frame_rejected, dual_move_cmd, motion_param_cmd;
    logic otp_byte_program_cmd, stall_detect_param_cmd, move_with_params_cmd;
    logic safe_position_cmd, immediate_halt_cmd, zero_here_cmd, decel_halt_cmd;
    logic [3:0] frame_length;
    logic [39:0] cmd_data, dat;
    logic [10:0] obs;
    logic [50:0] exp_q [$];
    logic [31:0] seed = 32'h1C09;
    logic [7:0] wcode [5] = '{`LCD_CMD_DUAL_MOVE, `LCD_CMD_MOTION_PARAM,
        `LCD_CMD_OTP_BYTE, `LCD_CMD_STALL_PARAM, `LCD_CMD_MOVE_PARAMS};
    logic [7:0] acode [4] = '{`LCD_CMD_SAFE_POS, `LCD_CMD_HALT,
        `LCD_CMD_ZERO, `LCD_CMD_DECEL_HALT};
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    assign {external_switch_flag, missed_step_flag, electrical_defect_flag,
        undervoltage_flag, thermal_shutdown_flag, thermal_warning_flag, temp_info} = stat;
    assign obs = {tx_valid, frame_rejected, dual_move_cmd, motion_param_cmd,
        otp_byte_program_cmd, stall_detect_param_cmd, move_with_params_cmd,
        safe_position_cmd, immediate_halt_cmd, zero_here_cmd, decel_halt_cmd};

    lcd_frame_decoder i_lcd_frame_decoder (.*);
    lcd_master_model i_lcd_master_model (.*);

    initial begin
        forever #2.5 clock = ~clock;
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [50:0] seen, input logic [50:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic frame(input logic [7:0] pid, input logic [63:0] b, input int n,
                         input logic ok, input logic [3:0] len);
        fork
            i_lcd_master_model.send_frame(pid, b, n, ok);
            begin
                repeat (2) @(negedge clock);
                check({47'h0, frame_length}, {47'h0, len});
            end
        join
    endtask

    // Kind k: 0 wide, 1 addressed, 2 bare; r: 0 own, 1 broadcast, 2 foreign
    task automatic wr(input int k, input int i, input int r, input logic ok);
        logic [7:0] nad;
        logic [7:0] code;
        logic [39:0] d;
        logic [10:0] m;
        int n;
        nad = r == 0 ? node_address : r == 1 ? `LCD_NAD_BROADCAST : node_address ^ 8'h01;
        code = i < 0 ? (k == 0 ? 8'h04 : 8'h08) : k == 0 ? wcode[i] : acode[i];
        d = {rnd(), 8'h5A};
        for (int j = int'(rnd() % 6); j < 5; j++)
            d[39 - 8 * j -: 8] = `LCD_UNUSED_BYTE;
        m = (i < 0 || !ok || (k != 2 && r == 2)) ? 11'h200 : k == 0 ? 11'h100 >> i : 11'h008 >> i;
        exp_q.push_back({m, (k == 0 && m != 11'h200) ? d : 40'h0});
        n = k == 0 ? 7 : 3 - k;
        frame(k == 0 ? pid_wide : k == 1 ? pid_addr : pid_bare,
              k == 0 ? {nad, code, d, 8'h0} : k == 1 ? {nad, code, 48'h0} : {code, 56'h0},
              n, ok, n[3:0]);
    endtask

    always @(negedge clock) begin
        if (rstn === 1'b1 && obs !== 11'h000) begin
            dat = tx_valid ? {32'h0, tx_byte} : (|obs[8:4] ? cmd_data : 40'h0);
            if (exp_q.size() == 0)
                check({obs, dat}, 51'h0);
            else
                check({obs, dat}, exp_q.pop_front());
        end
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            complete_run();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        node_address = 8'(rnd()) & 8'h3F;
        repeat (2) @(posedge clock);
        @(negedge clock);
        rstn = 1'b1;
        check({11'h0, cmd_data}, {11'h0, {5{8'hFF}}});
        for (int r = 0; r < 3; r++)
            for (int i = 0; i < 5; i++)
                wr(0, i, r, 1'b1);
        for (int r = 0; r < 3; r++)
            for (int i = 0; i < 4; i++) begin
                wr(1, i, r, 1'b1);
                wr(2, i, 0, 1'b1);
            end
        for (int k = 0; k < 3; k++) begin
            wr(k, -1, 0, 1'b1);
            wr(k, k, 1, 1'b0);
        end
        repeat (4) begin
            stat = 8'(rnd());
            exp_q.push_back({11'h400, 32'h0, stat});
            frame(pid_status, 64'h0, 0, 1'b1, `LCD_LEN_STATUS);
        end
        foreach (wcode[j]) begin
            pid_bare = j[0] ? `LCD_PID_DIAG_RESP : `LCD_PID_DIAG_REQ;
            frame(pid_bare, {8'h04, 56'h0}, 1, 1'b1, 4'h0);
        end
        pid_bare = 8'h33;
        frame(8'h55, {8'h05, 56'h0}, 1, 1'b1, 4'h0);
        repeat (8) @(negedge clock);
        check(51'(exp_q.size()), 51'h0);
        complete_run();
    end
endmodule // lcd_frame_decoder_tb_top
